// *** rtl/i2cbf_cfg.svh ***
// constants for the two-wire bus framing block
// Functional notes
// - each bus unit is nine bits: eight data bits then one acknowledge bit
// - sender releases SDA after the eighth falling SCL and samples acknowledge next pulse
// - the master drives SCL; a slave may stretch it by holding SCL low, which lengthens the phase
// - SDA changes only while SCL low; receiver captures on SCL rising edge
// - SDA change while SCL high is Start or Stop, never data
// - SDA held valid after SCL falls for a two-bit selectable hold time
// - Start is SDA falling while SCL high; generated only as master
// - master waits for bus free flag before driving a Start
// - simultaneous Start by another master shows as collision in address phase
// - Stop is SDA rising while SCL high
// - Stop valid only after one SCL low period following Start
// - SDA and SCL are open drain: pull low or release only
`ifndef I2CBF_CFG_SVH
`define I2CBF_CFG_SVH

`define I2CBF_CLK_MHZ      100
`define I2CBF_SCL_LOW_NS   5000
`define I2CBF_SCL_HIGH_NS  5000
`define I2CBF_HOLD0_NS     100
`define I2CBF_HOLD1_NS     300
`define I2CBF_HOLD2_NS     600
`define I2CBF_HOLD3_NS     1000
`define I2CBF_NS2CYC(ns)   ((((ns) * `I2CBF_CLK_MHZ) + 999) / 1000)
`define I2CBF_BITS_BYTE    8
`define I2CBF_BUS_FREE_RST 1'b1
`define I2CBF_FIFO_DEPTH   2

`endif

// *** rtl/i2cbf_pkg.sv ***
// types shared by the bus framing block
package i2cbf_pkg;

    typedef enum logic [7:0] {
        I2CBF_IDLE  = 8'h01,
        I2CBF_START = 8'h02,
        I2CBF_LOW   = 8'h04,
        I2CBF_HIGH  = 8'h08,
        I2CBF_WAIT  = 8'h10,
        I2CBF_STOPL = 8'h20,
        I2CBF_STOPH = 8'h40,
        I2CBF_STOPR = 8'h80
    } i2cbf_fsm_e;

    // one word queued for transmission
    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } i2cbf_txw_s;

    // one nine-bit unit seen on the bus
    typedef struct packed {
        logic [7:0] data;
        logic       ack;
    } i2cbf_rxw_s;

endpackage

// *** rtl/i2cbf_fifo.sv ***
// small valid/ready buffer in front of the transmit path
`timescale 1ns/100ps
module i2cbf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             mclk_in,
    input  wire logic             srst_in,
    // fill side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // drain side
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("i2cbf_fifo depth must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        rdy;
        logic                        vld;
    } fifo_st_s;

    fifo_st_s st_r;
    fifo_st_s st_nxt;
    logic     push;
    logic     pop;

    always_comb begin
        st_nxt = st_r;
        push   = in_valid_in && st_r.rdy;
        pop    = out_ready_in && st_r.vld;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data_in;
            st_nxt.wp           = st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        st_nxt.rdy = st_nxt.cnt != (AW+1)'(DEPTH);
        st_nxt.vld = st_nxt.cnt != '0;
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            st_r     <= '0;
            st_r.rdy <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign in_ready_out  = st_r.rdy;
    assign out_valid_out = st_r.vld;
    assign out_data_out  = st_r.mem[st_r.rp];
endmodule // i2cbf_fifo

// *** rtl/i2cbf_top.sv ***
// two-wire bus framing: start/stop generation and detection, byte/ack framing
`timescale 1ns/100ps
`include "i2cbf_cfg.svh"
module i2cbf_top #(
    parameter int SCL_LOW_CYC  = `I2CBF_NS2CYC(`I2CBF_SCL_LOW_NS),
    parameter int SCL_HIGH_CYC = `I2CBF_NS2CYC(`I2CBF_SCL_HIGH_NS),
    parameter int FIFO_DEPTH   = `I2CBF_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                 mclk_in,
    input  wire logic                 srst_in,
    // bus pins, open drain
    input  wire logic                 scl_in,
    output logic                      scl_out,
    output logic                      scl_oe_out,
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe_out,
    // configuration
    input  wire logic [1:0]           sda_hold_select_in,
    // transmit stream
    input  wire logic                 tx_valid_in,
    input  wire i2cbf_pkg::i2cbf_txw_s tx_word_in,
    output logic                      tx_ready_out,
    // receive stream and events
    output logic                      rx_valid_out,
    output i2cbf_pkg::i2cbf_rxw_s     rx_word_out,
    output logic                      ack_valid_out,
    output logic                      nack_out,
    output logic                      collision_out,
    output logic                      start_det_out,
    output logic                      stop_det_out,
    output logic                      bus_free_flag_out,
    output logic                      busy_out
);
    localparam logic [11:0] LOW_END  = 12'(SCL_LOW_CYC - 1);
    localparam logic [11:0] HIGH_END = 12'(SCL_HIGH_CYC - 1);
    localparam int HOLD_MAX = `I2CBF_NS2CYC(`I2CBF_HOLD3_NS);

    if (SCL_LOW_CYC < HOLD_MAX + 2 || SCL_LOW_CYC > 4096 || SCL_HIGH_CYC < 2
            || SCL_HIGH_CYC > 4096) begin : g_chk
        $error("i2cbf_top SCL phase counts out of range");
    end

    // hold time in cycles after our own SCL falling edge
    function automatic logic [11:0] hold_cyc(input logic [1:0] sel);
        case (sel)
            2'h0:    hold_cyc = 12'(`I2CBF_NS2CYC(`I2CBF_HOLD0_NS));
            2'h1:    hold_cyc = 12'(`I2CBF_NS2CYC(`I2CBF_HOLD1_NS));
            2'h2:    hold_cyc = 12'(`I2CBF_NS2CYC(`I2CBF_HOLD2_NS));
            default: hold_cyc = 12'(`I2CBF_NS2CYC(`I2CBF_HOLD3_NS));
        endcase
    endfunction

    typedef struct packed {
        i2cbf_pkg::i2cbf_fsm_e fsm;
        logic [1:0]            scl_sy;
        logic [1:0]            sda_sy;
        logic                  scl_p;
        logic                  sda_p;
        logic                  active;
        logic                  low_seen;
        logic                  bus_free;
        logic [3:0]            rbit;
        logic [7:0]            rsh;
        logic [3:0]            mbit;
        logic [7:0]            txb;
        logic                  last;
        logic                  first;
        logic [11:0]           tmr;
        logic                  scl_o;
        logic                  scl_oe;
        logic                  sda_o;
        logic                  sda_oe;
        logic                  rxv;
        i2cbf_pkg::i2cbf_rxw_s rxw;
        logic                  ackv;
        logic                  nack;
        logic                  coll;
        logic                  startp;
        logic                  stopp;
        logic                  busy;
    } top_st_s;

    top_st_s               st_r;
    top_st_s               st_nxt;
    logic                  q_valid;
    i2cbf_pkg::i2cbf_txw_s q_word;
    logic                  q_pop;
    logic                  scl;
    logic                  sda;
    logic                  start_det;
    logic                  stop_det;
    logic [11:0]           hold;

    i2cbf_fifo #(
        .WIDTH ($bits(i2cbf_pkg::i2cbf_txw_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_txq (
        .mclk_in       (mclk_in),
        .srst_in       (srst_in),
        .in_valid_in   (tx_valid_in),
        .in_data_in    (tx_word_in),
        .in_ready_out  (tx_ready_out),
        .out_valid_out (q_valid),
        .out_data_out  (q_word),
        .out_ready_in  (q_pop)
    );

    always_comb begin
        st_nxt        = st_r;
        q_pop         = 1'b0;
        hold          = hold_cyc(sda_hold_select_in);
        // second synchroniser stage only is read by logic
        st_nxt.scl_sy = {st_r.scl_sy[0], scl_in};
        st_nxt.sda_sy = {st_r.sda_sy[0], sda_in};
        scl           = st_r.scl_sy[1];
        sda           = st_r.sda_sy[1];
        st_nxt.scl_p  = scl;
        st_nxt.sda_p  = sda;
        st_nxt.rxv    = 1'b0;
        st_nxt.ackv   = 1'b0;
        st_nxt.coll   = 1'b0;
        // SDA moving while SCL stays high is a condition, not data
        start_det     = scl && st_r.scl_p && st_r.sda_p && !sda;
        stop_det      = scl && st_r.scl_p && !st_r.sda_p && sda && st_r.low_seen;
        st_nxt.startp = start_det;
        st_nxt.stopp  = stop_det;

        // bus monitor
        if (start_det) begin
            st_nxt.active   = 1'b1;
            st_nxt.low_seen = 1'b0;
            st_nxt.bus_free = 1'b0;
            st_nxt.rbit     = 4'h0;
        end else if (stop_det) begin
            st_nxt.active   = 1'b0;
            st_nxt.low_seen = 1'b0;
            st_nxt.bus_free = 1'b1;
        end else if (st_r.active) begin
            if (!scl) begin
                st_nxt.low_seen = 1'b1;
            end
            if (scl && !st_r.scl_p) begin
                if (st_r.rbit == 4'(`I2CBF_BITS_BYTE)) begin
                    st_nxt.rxv      = 1'b1;
                    st_nxt.rxw.data = st_r.rsh;
                    st_nxt.rxw.ack  = !sda;
                    st_nxt.rbit     = 4'h0;
                end else begin
                    st_nxt.rsh  = {st_r.rsh[6:0], sda};
                    st_nxt.rbit = st_r.rbit + 4'h1;
                end
            end
        end

        // master sequencer; outputs only ever pull low or release
        case (st_r.fsm)
            i2cbf_pkg::I2CBF_IDLE: begin
                st_nxt.scl_oe = 1'b0;
                st_nxt.sda_oe = 1'b0;
                st_nxt.busy   = 1'b0;
                st_nxt.tmr    = 12'h000;
                if (q_valid && st_r.bus_free && scl && sda) begin
                    q_pop         = 1'b1;
                    st_nxt.txb    = q_word.data;
                    st_nxt.last   = q_word.last;
                    st_nxt.first  = 1'b1;
                    st_nxt.busy   = 1'b1;
                    st_nxt.sda_oe = 1'b1;
                    st_nxt.fsm    = i2cbf_pkg::I2CBF_START;
                end
            end
            i2cbf_pkg::I2CBF_START: begin
                st_nxt.tmr = st_r.tmr + 12'h001;
                if (st_r.tmr == HIGH_END) begin
                    st_nxt.tmr    = 12'h000;
                    st_nxt.mbit   = 4'h0;
                    st_nxt.scl_oe = 1'b1;
                    st_nxt.fsm    = i2cbf_pkg::I2CBF_LOW;
                end
            end
            i2cbf_pkg::I2CBF_LOW: begin
                st_nxt.tmr = st_r.tmr + 12'h001;
                if (st_r.tmr == hold) begin
                    // ninth bit: release SDA so the receiver can answer
                    st_nxt.sda_oe = (st_r.mbit < 4'(`I2CBF_BITS_BYTE)) && !st_r.txb[7];
                end
                if (st_r.tmr == LOW_END) begin
                    st_nxt.tmr    = 12'h000;
                    st_nxt.scl_oe = 1'b0;
                    st_nxt.fsm    = i2cbf_pkg::I2CBF_HIGH;
                end
            end
            i2cbf_pkg::I2CBF_HIGH: begin
                // count only once SCL really reads high, so a stretching
                // slave or a slower master lengthens the phase
                if (scl) begin
                    st_nxt.tmr = st_r.tmr + 12'h001;
                    if (st_r.first && st_r.mbit < 4'(`I2CBF_BITS_BYTE)
                            && !st_r.sda_oe && !sda) begin
                        st_nxt.coll = 1'b1;
                        st_nxt.busy = 1'b0;
                        st_nxt.fsm  = i2cbf_pkg::I2CBF_IDLE;
                    end else if (st_r.tmr == HIGH_END) begin
                        st_nxt.tmr    = 12'h000;
                        st_nxt.scl_oe = 1'b1;
                        if (st_r.mbit < 4'(`I2CBF_BITS_BYTE)) begin
                            st_nxt.txb  = {st_r.txb[6:0], 1'b0};
                            st_nxt.mbit = st_r.mbit + 4'h1;
                            st_nxt.fsm  = i2cbf_pkg::I2CBF_LOW;
                        end else begin
                            st_nxt.ackv  = 1'b1;
                            st_nxt.nack  = sda;
                            st_nxt.first = 1'b0;
                            st_nxt.fsm   = (sda || st_r.last) ? i2cbf_pkg::I2CBF_STOPL
                                                              : i2cbf_pkg::I2CBF_WAIT;
                        end
                    end
                end
            end
            i2cbf_pkg::I2CBF_WAIT: begin
                // SCL is held low while the queue is empty
                if (q_valid) begin
                    q_pop       = 1'b1;
                    st_nxt.txb  = q_word.data;
                    st_nxt.last = q_word.last;
                    st_nxt.mbit = 4'h0;
                    st_nxt.tmr  = 12'h000;
                    st_nxt.fsm  = i2cbf_pkg::I2CBF_LOW;
                end
            end
            i2cbf_pkg::I2CBF_STOPL: begin
                st_nxt.tmr = st_r.tmr + 12'h001;
                if (st_r.tmr == hold) begin
                    st_nxt.sda_oe = 1'b1;
                end
                if (st_r.tmr == LOW_END) begin
                    st_nxt.tmr    = 12'h000;
                    st_nxt.scl_oe = 1'b0;
                    st_nxt.fsm    = i2cbf_pkg::I2CBF_STOPH;
                end
            end
            i2cbf_pkg::I2CBF_STOPH: begin
                if (scl) begin
                    st_nxt.tmr = st_r.tmr + 12'h001;
                    if (st_r.tmr == HIGH_END) begin
                        st_nxt.tmr    = 12'h000;
                        st_nxt.sda_oe = 1'b0;
                        st_nxt.fsm    = i2cbf_pkg::I2CBF_STOPR;
                    end
                end
            end
            i2cbf_pkg::I2CBF_STOPR: begin
                st_nxt.tmr = st_r.tmr + 12'h001;
                if (st_r.tmr == HIGH_END) begin
                    st_nxt.tmr  = 12'h000;
                    st_nxt.busy = 1'b0;
                    st_nxt.fsm  = i2cbf_pkg::I2CBF_IDLE;
                end
            end
            default: begin
                st_nxt.scl_oe = 1'b0;
                st_nxt.sda_oe = 1'b0;
                st_nxt.fsm    = i2cbf_pkg::I2CBF_IDLE;
            end
        endcase
        // a lost arbitration or idle state never leaves the lines pulled
        if (st_nxt.fsm == i2cbf_pkg::I2CBF_IDLE) begin
            st_nxt.scl_oe = 1'b0;
            st_nxt.sda_oe = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            st_r          <= '0;
            st_r.fsm      <= i2cbf_pkg::I2CBF_IDLE;
            st_r.scl_sy   <= 2'h3;
            st_r.sda_sy   <= 2'h3;
            st_r.scl_p    <= 1'b1;
            st_r.sda_p    <= 1'b1;
            st_r.bus_free <= `I2CBF_BUS_FREE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign scl_out           = st_r.scl_o;
    assign scl_oe_out        = st_r.scl_oe;
    assign sda_out           = st_r.sda_o;
    assign sda_oe_out        = st_r.sda_oe;
    assign rx_valid_out      = st_r.rxv;
    assign rx_word_out       = st_r.rxw;
    assign ack_valid_out     = st_r.ackv;
    assign nack_out          = st_r.nack;
    assign collision_out     = st_r.coll;
    assign start_det_out     = st_r.startp;
    assign stop_det_out      = st_r.stopp;
    assign bus_free_flag_out = st_r.bus_free;
    assign busy_out          = st_r.busy;
endmodule // i2cbf_top

// *** verification/i2cbf_asserts.sv ***
// concurrent checks on the framing block's ports
`timescale 1ns/100ps
module i2cbf_chk #(
    parameter int SCL_LOW_CYC = 120
) (
    // clock and reset
    input wire logic       mclk_in,
    input wire logic       srst_in,
    // bus pins and SDA hold select
    input wire logic       scl_out,
    input wire logic       scl_oe_out,
    input wire logic       sda_out,
    input wire logic       sda_oe_out,
    input wire logic [1:0] sda_hold_select_in,
    // events
    input wire logic       rx_valid_out,
    input wire logic       ack_valid_out,
    input wire logic       nack_out,
    input wire logic       collision_out,
    input wire logic       start_det_out,
    input wire logic       stop_det_out,
    input wire logic       bus_free_flag_out
);
    int unsigned since_r;
    int unsigned since_nxt;
    int unsigned hold_cyc;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    // cycles since our SCL pull began; a long WAIT stretch is kept out by the low-phase bound
    always_comb begin
        since_nxt = scl_oe_out ? since_r + 32'h1 : 32'h0;
        case (sda_hold_select_in)
            2'h0: hold_cyc = 32'h0A;
            2'h1: hold_cyc = 32'h1E;
            2'h2: hold_cyc = 32'h3C;
            default: hold_cyc = 32'h64;
        endcase
    end
    always_ff @(posedge mclk_in) begin
        since_r <= srst_in ? 32'h0 : since_nxt;
    end

    pins_low_only_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("pin output value not low");
    start_needs_free_a: assert property (($rose(sda_oe_out) && !scl_oe_out) |-> $past(bus_free_flag_out))
        else $error("start driven while bus not free");
    high_phase_stable_a: assert property ($fell(scl_oe_out) |-> $stable(sda_oe_out) [*8])
        else $error("data changed while clock high");
    hold_time_a: assert property ((scl_oe_out && $changed(sda_oe_out) && since_r < SCL_LOW_CYC)
        |-> (since_r + 32'h1 >= hold_cyc && since_r <= hold_cyc + 32'h2))
        else $error("data hold time off");
    free_clear_a: assert property (start_det_out |=> !bus_free_flag_out)
        else $error("bus free not cleared by start");
    free_set_a: assert property (stop_det_out |=> bus_free_flag_out)
        else $error("bus free not set by stop");
    stop_when_busy_a: assert property (stop_det_out |-> !$past(bus_free_flag_out) && !start_det_out)
        else $error("stop seen without open frame");
    coll_release_a: assert property (collision_out |=> !scl_oe_out && !sda_oe_out)
        else $error("lines held after collision");
    ack_release_a: assert property (ack_valid_out |-> !sda_oe_out && !$past(sda_oe_out))
        else $error("data held during acknowledge bit");
    rx_pulse_a: assert property (rx_valid_out |=> !rx_valid_out)
        else $error("unit flag longer than one cycle");

    cover property (collision_out);
    cover property (ack_valid_out && nack_out);
    cover property (stop_det_out ##1 bus_free_flag_out);
endmodule // i2cbf_chk

// *** verification/i2cbf_slave.sv ***
// behavioural slave on the shared two-wire bus
`timescale 1ns/100ps
module i2cbf_slave (
    // bus wires
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    // control
    input  wire logic       ack_en_in,
    output logic            sda_low_out,
    output logic [7:0]      byte_out
);
    int         cnt = 0;
    logic       act = 1'b0;
    logic [7:0] sh  = 8'h00;

    initial begin
        sda_low_out = 1'b0;
        byte_out    = 8'h00;
    end
    // the start's own clock fall must not count as a bit
    always @(negedge sda_in) if (scl_in === 1'b1) begin
        act = 1'b1;
        cnt = -1;
    end
    always @(posedge sda_in) if (scl_in === 1'b1) act = 1'b0;
    always @(posedge scl_in) if (act && cnt >= 0 && cnt < 8) sh = {sh[6:0], sda_in};
    // only pulls low or releases, so the pull-up decides a released line
    always @(negedge scl_in) if (act) begin
        cnt++;
        if (cnt == 8) begin
            byte_out    = sh;
            sda_low_out = ack_en_in;
        end else if (cnt == 9) begin
            sda_low_out = 1'b0;
            cnt = 0;
        end
    end
endmodule // i2cbf_slave

// *** verification/tb_top.sv ***
// self-checking bench for the two-wire framing block
`timescale 1ns/100ps
`define I2CBF_CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin fail_count++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_top;
    localparam int LOW_CYC  = 120;
    localparam int HIGH_CYC = 20;
    logic mclk = 1'b0, srst = 1'b1, tx_valid = 1'b0, ack_en = 1'b1;
    logic fm_scl_low = 1'b0, fm_sda_low = 1'b0, full_seen = 1'b0, oe_seen = 1'b0, fm_win = 1'b0;
    logic [1:0] hold_sel = 2'h0;
    logic scl_o, scl_oe, sda_o, sda_oe, tx_ready, rx_valid, ack_valid, nack;
    logic coll, start_det, stop_det, bus_free, busy, slv_low;
    logic [7:0] slv_byte, last_d, d, fd;
    i2cbf_pkg::i2cbf_txw_s tx_word = '0;
    i2cbf_pkg::i2cbf_rxw_s rx_word, w;
    i2cbf_pkg::i2cbf_rxw_s rxq[$];
    logic [7:0] expq[$];
    logic nackq[$];
    logic e1;
    int fail_count = 0, checks = 0, n_start = 0, n_stop = 0, n_coll = 0, ns, np, nc;
    wire scl_w = !(scl_oe | fm_scl_low);
    wire sda_w = !(sda_oe | fm_sda_low | slv_low);

    always #5 mclk = ~mclk;

    i2cbf_top #(.SCL_LOW_CYC(LOW_CYC), .SCL_HIGH_CYC(HIGH_CYC), .FIFO_DEPTH(2)) uut (
        .mclk_in(mclk), .srst_in(srst), .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe),
        .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe), .sda_hold_select_in(hold_sel),
        .tx_valid_in(tx_valid), .tx_word_in(tx_word), .tx_ready_out(tx_ready),
        .rx_valid_out(rx_valid), .rx_word_out(rx_word), .ack_valid_out(ack_valid),
        .nack_out(nack), .collision_out(coll), .start_det_out(start_det),
        .stop_det_out(stop_det), .bus_free_flag_out(bus_free), .busy_out(busy));
    i2cbf_slave slave (.scl_in(scl_w), .sda_in(sda_w), .ack_en_in(ack_en),
        .sda_low_out(slv_low), .byte_out(slv_byte));

    always @(posedge mclk) if (srst === 1'b0) begin
        if (rx_valid === 1'b1) rxq.push_back(rx_word);
        if (ack_valid === 1'b1) nackq.push_back(nack);
        if (start_det === 1'b1) n_start++;
        if (stop_det === 1'b1) n_stop++;
        if (coll === 1'b1) n_coll++;
        if (tx_valid && tx_ready === 1'b0) full_seen = 1'b1;
        if (fm_win && (scl_oe !== 1'b0 || sda_oe !== 1'b0)) oe_seen = 1'b1;
    end

    task step; @(posedge mclk); #1; endtask
    // valid stays up between words so no edge sees a stale word twice
    task send(input logic lst, input logic [7:0] dv);
        tx_valid = 1'b1;
        tx_word  = '{last: lst, data: dv};
        @(posedge mclk);
        while (tx_ready !== 1'b1) @(posedge mclk);
        #1;
    endtask
    task frame(input int n, input logic [7:0] first);
        step();
        for (int i = 0; i < n; i++) begin
            last_d = (i == 0) ? first : 8'($urandom);
            expq.push_back(last_d);
            send(i == n - 1, last_d);
        end
        tx_valid = 1'b0;
    endtask
    task wait_idle;
        int k;
        k = 0;
        repeat (8) @(posedge mclk);
        while (busy !== 1'b0 && k < 40000) begin
            @(posedge mclk);
            k++;
        end
        repeat (10) @(posedge mclk);
        #1;
        `I2CBF_CHK("frame end", 1'b1, k < 40000)
    endtask
    task check_rx(input logic ackv);
        `I2CBF_CHK("unit count", expq.size(), rxq.size())
        while (expq.size() > 0 && rxq.size() > 0) begin
            w  = rxq.pop_front();
            fd = expq.pop_front();
            `I2CBF_CHK("rx data", fd, w.data)
            `I2CBF_CHK("rx ack", ackv, w.ack)
        end
        while (nackq.size() > 0) begin
            e1 = nackq.pop_front();
            `I2CBF_CHK("nack", !ackv, e1)
        end
        expq.delete();
        rxq.delete();
    endtask
    // foreign master at a 125 ns clock, data moved only while its clock is low
    task fm_bit(input logic b);
        #20 fm_sda_low = !b;
        #42.5 fm_scl_low = 1'b0;
        #62.5 fm_scl_low = 1'b1;
    endtask
    task fm_stop;
        #20 fm_sda_low = 1'b1;
        #42.5 fm_scl_low = 1'b0;
        #62.5 fm_sda_low = 1'b0;
        // our own start may follow this stop within a few cycles
        fm_win = 1'b0;
        #62.5;
    endtask

    task end_of_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #900_000;
        fail_count++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'hA93B40F7));
        repeat (20) @(posedge mclk);
        #1 srst = 1'b0;
        step();
        `I2CBF_CHK("bus free reset", 1'b1, bus_free)
        `I2CBF_CHK("scl pull reset", 1'b0, scl_oe)
        `I2CBF_CHK("sda pull reset", 1'b0, sda_oe)
        for (int h = 0; h < 4; h++) begin
            hold_sel = 2'(h);
            ns = n_start;
            np = n_stop;
            frame(h + 1, 8'($urandom));
            wait_idle();
            check_rx(1'b1);
            `I2CBF_CHK("slave byte", last_d, slv_byte)
            `I2CBF_CHK("starts", 1, n_start - ns)
            `I2CBF_CHK("stops", 1, n_stop - np)
            `I2CBF_CHK("free after", 1'b1, bus_free)
        end
        `I2CBF_CHK("queue full", 1'b1, full_seen)
        ack_en = 1'b0;
        np = n_stop;
        frame(1, 8'($urandom));
        wait_idle();
        check_rx(1'b0);
        `I2CBF_CHK("stop on nack", 1, n_stop - np)
        ack_en = 1'b1;
        ns = n_start;
        fm_win = 1'b1;
        fm_sda_low = 1'b1;
        #62.5 fm_scl_low = 1'b1;
        d  = 8'($urandom);
        fd = 8'($urandom);
        expq.push_back(fd);
        expq.push_back(d);
        step();
        send(1'b1, d);
        tx_valid = 1'b0;
        `I2CBF_CHK("free in frame", 1'b0, bus_free)
        for (int i = 7; i >= 0; i--) fm_bit(fd[i]);
        fm_bit(1'b1);
        fm_stop();
        `I2CBF_CHK("waits for free", 1'b0, oe_seen)
        wait_idle();
        check_rx(1'b1);
        `I2CBF_CHK("starts both", 2, n_start - ns)
        ns = n_start;
        np = n_stop;
        fm_sda_low = 1'b1;
        #200 fm_sda_low = 1'b0;
        #200;
        `I2CBF_CHK("start only", 1, n_start - ns)
        `I2CBF_CHK("no early stop", 0, n_stop - np)
        `I2CBF_CHK("still taken", 1'b0, bus_free)
        fm_scl_low = 1'b1;
        #62.5;
        fm_stop();
        repeat (10) @(posedge mclk);
        #1;
        `I2CBF_CHK("late stop", 1, n_stop - np)
        `I2CBF_CHK("free again", 1'b1, bus_free)
        nc = n_coll;
        step();
        send(1'b1, 8'hFF);
        tx_valid = 1'b0;
        for (int k = 0; k < 2000 && scl_oe !== 1'b1; k++) @(posedge mclk);
        // rival address bit 0 goes out while SCL is low, as a data bit must
        #1 fm_sda_low = 1'b1;
        for (int k = 0; k < 2000 && scl_oe !== 1'b0; k++) @(posedge mclk);
        repeat (40) @(posedge mclk);
        #1;
        `I2CBF_CHK("collision", 1, n_coll - nc)
        `I2CBF_CHK("scl freed", 1'b0, scl_oe)
        `I2CBF_CHK("sda freed", 1'b0, sda_oe)
        fm_sda_low = 1'b0;
        end_of_test();
    end
endmodule // tb_top

bind i2cbf_top i2cbf_chk #(.SCL_LOW_CYC(SCL_LOW_CYC)) chk (
    .mclk_in(mclk_in), .srst_in(srst_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .sda_hold_select_in(sda_hold_select_in),
    .rx_valid_out(rx_valid_out), .ack_valid_out(ack_valid_out), .nack_out(nack_out),
    .collision_out(collision_out), .start_det_out(start_det_out),
    .stop_det_out(stop_det_out), .bus_free_flag_out(bus_free_flag_out));
